// File: fpm_defs.svh
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// ==================================================
// Reset values of the settings
`define FPM_RST_RATED_I 20'h00020
`define FPM_RST_SHUNT_MV 12'h100
`define FPM_RST_RATED_V 16'h0000
`define FPM_RST_PASS 16'h0000
`define FPM_RST_LAMP 3'h5
`define FPM_RST_DATE 24'h000101
`define FPM_RST_TIME 24'h000000

// ==================================================
// Accepted ranges, packed decimal digits
`define FPM_RATED_I_MIN 20'h00020
`define FPM_RATED_I_MAX 20'h50000
`define FPM_SHUNT_MIN 12'h050
`define FPM_SHUNT_MAX 12'h100
`define FPM_MONTH_MIN 8'h01
`define FPM_MONTH_MAX 8'h12
`define FPM_DAY_MIN 8'h01
`define FPM_DAY_MAX 8'h31
`define FPM_HOUR_MAX 8'h23
`define FPM_LAMP_MIN 3'h1
`define FPM_LAMP_MAX 3'h5

// ==================================================
// Digit counts of the edited screens, and the clear count that means yes
`define FPM_DIG_RATED_I 3'h5
`define FPM_DIG_SHUNT 3'h3
`define FPM_DIG_RATED_V 3'h4
`define FPM_DIG_PASS 3'h4
`define FPM_DIG_CLOCK 3'h6
`define FPM_CLR_YES 2'h2

// ==================================================
// Key synchroniser depth
`define FPM_SYNC_STAGES 2

`endif

// File: fpm_pkg.sv
package fpm_pkg;

  // ==================================================
  // Menu screens
  typedef enum logic [13:0] {
    SCR_METER    = 14'h0001,
    SCR_PASS_IN  = 14'h0002,
    SCR_RATED_I  = 14'h0004,
    SCR_SHUNT    = 14'h0008,
    SCR_I_RANGE  = 14'h0010,
    SCR_RATED_V  = 14'h0020,
    SCR_V_RANGE  = 14'h0040,
    SCR_E_CLR    = 14'h0080,
    SCR_AH_CLR   = 14'h0100,
    SCR_CNT_CLR  = 14'h0200,
    SCR_LAMP     = 14'h0400,
    SCR_DATE     = 14'h0800,
    SCR_TIME     = 14'h1000,
    SCR_PASS_SET = 14'h2000
  } fpm_screen_t;

  // ==================================================
  // Stored settings
  typedef struct packed {
    logic [19:0] rated_i;
    logic [11:0] shunt_mv;
    logic i_range;
    logic [15:0] rated_v;
    logic v_range;
    logic [2:0] lamp;
    logic [23:0] date;
    logic [23:0] time_of_day;
    logic [15:0] pass;
  } fpm_cfg_t;

  // ==================================================
  // One-cycle event pulses
  typedef struct packed {
    logic energy_clr;
    logic charge_clr;
    logic count_clr;
    logic pass_fail;
    logic date_load;
    logic time_load;
  } fpm_pulse_t;

  // ==================================================
  // Whole state of the menu controller
  typedef struct packed {
    fpm_screen_t screen;
    logic set_icon;
    logic edit;
    logic [2:0] cursor;
    logic [23:0] ebuf;
    logic [15:0] entry;
    logic [1:0] clr_cnt;
    logic [2:0] lamp_sel;
    logic sel;
    fpm_cfg_t cfg;
    fpm_pulse_t pulse;
    logic inc_prev;
    logic adv_prev;
    logic combo_seen;
  } fpm_state_t;

endpackage

// File: fpm_key_sync.sv
`timescale 1ns/1ns
`include "fpm_defs.svh"

module fpm_key_sync #(
  parameter int STAGES = `FPM_SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin and synchronised level
  input wire logic key_pin,
  output logic key_sync
);

  // ==================================================
  // Parameter check
  if (STAGES < 2) begin
    $error("fpm_key_sync: STAGES must be at least 2");
  end

  // ==================================================
  // Shift chain, only the last stage is read
  typedef struct packed {
    logic [STAGES-1:0] chain;
  } fpm_sync_t;

  fpm_sync_t st_q;
  fpm_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.chain = {st_q.chain[STAGES-2:0], key_pin};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign key_sync = st_q.chain[STAGES-1];

endmodule

// File: fpm_menu.sv
`timescale 1ns/1ns
`include "fpm_defs.svh"

module fpm_menu (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Front-panel keys, raw pins, high while pressed
  input wire logic inc_key,
  input wire logic adv_key,
  // Wiring straps
  input wire logic indirect_current,
  input wire logic hall_current,
  // Display state
  output fpm_pkg::fpm_screen_t screen,
  output logic set_icon,
  output logic edit_active,
  output logic [2:0] cursor,
  output logic [23:0] edit_digits,
  output logic [1:0] clear_count,
  output logic [2:0] lamp_sel,
  output logic range_sel,
  // Settings and events
  output fpm_pkg::fpm_cfg_t cfg,
  output fpm_pkg::fpm_pulse_t pulse
);

  logic inc_s;
  logic adv_s;
  logic ind_s;
  logic hall_s;
  logic ev_combo;
  logic ev_inc;
  logic ev_adv;
  fpm_pkg::fpm_state_t st_q;
  fpm_pkg::fpm_state_t st_d;

  // ==================================================
  // Pin synchronisers
  fpm_key_sync u_sync_inc (.clk(clk), .rst_n(rst_n), .key_pin(inc_key), .key_sync(inc_s));
  fpm_key_sync u_sync_adv (.clk(clk), .rst_n(rst_n), .key_pin(adv_key), .key_sync(adv_s));
  fpm_key_sync u_sync_ind (.clk(clk), .rst_n(rst_n), .key_pin(indirect_current), .key_sync(ind_s));
  fpm_key_sync u_sync_hall (.clk(clk), .rst_n(rst_n), .key_pin(hall_current), .key_sync(hall_s));

  // ==================================================
  // Key events: chord on press, single keys on release
  assign ev_combo = inc_s && adv_s && !st_q.combo_seen;
  assign ev_inc = st_q.inc_prev && !inc_s && !adv_s && !st_q.combo_seen;
  assign ev_adv = st_q.adv_prev && !adv_s && !inc_s && !st_q.combo_seen;

  // ==================================================
  // Screen tables
  function automatic logic [2:0] ndig(input fpm_pkg::fpm_screen_t s);
    case (s)
      fpm_pkg::SCR_RATED_I: ndig = `FPM_DIG_RATED_I;
      fpm_pkg::SCR_SHUNT: ndig = `FPM_DIG_SHUNT;
      fpm_pkg::SCR_RATED_V: ndig = `FPM_DIG_RATED_V;
      fpm_pkg::SCR_DATE: ndig = `FPM_DIG_CLOCK;
      fpm_pkg::SCR_TIME: ndig = `FPM_DIG_CLOCK;
      fpm_pkg::SCR_PASS_IN: ndig = `FPM_DIG_PASS;
      fpm_pkg::SCR_PASS_SET: ndig = `FPM_DIG_PASS;
      default: ndig = 3'h0;
    endcase
  endfunction

  function automatic logic [3:0] dig_max(input fpm_pkg::fpm_screen_t s, input logic [2:0] p);
    dig_max = 4'h9;
    case (s)
      fpm_pkg::SCR_RATED_I: if (p == 3'h4) dig_max = 4'h5;
      fpm_pkg::SCR_SHUNT: if (p == 3'h2) dig_max = 4'h1;
      fpm_pkg::SCR_RATED_V: if (p == 3'h3) dig_max = 4'h3;
      fpm_pkg::SCR_DATE: begin
        if (p == 3'h3) dig_max = 4'h1;
        if (p == 3'h1) dig_max = 4'h3;
      end
      fpm_pkg::SCR_TIME: begin
        if (p == 3'h5) dig_max = 4'h2;
        if (p == 3'h3 || p == 3'h1) dig_max = 4'h5;
      end
      default: dig_max = 4'h9;
    endcase
  endfunction

  function automatic logic [23:0] load(input fpm_pkg::fpm_state_t q, input fpm_pkg::fpm_screen_t s);
    case (s)
      fpm_pkg::SCR_RATED_I: load = {4'h0, q.cfg.rated_i};
      fpm_pkg::SCR_SHUNT: load = {12'h000, q.cfg.shunt_mv};
      fpm_pkg::SCR_RATED_V: load = {8'h00, q.cfg.rated_v};
      fpm_pkg::SCR_DATE: load = q.cfg.date;
      fpm_pkg::SCR_TIME: load = q.cfg.time_of_day;
      fpm_pkg::SCR_PASS_IN: load = {8'h00, q.entry};
      fpm_pkg::SCR_PASS_SET: load = {8'h00, q.cfg.pass};
      default: load = 24'h000000;
    endcase
  endfunction

  function automatic logic valid(input fpm_pkg::fpm_screen_t s, input logic [23:0] b);
    case (s)
      fpm_pkg::SCR_RATED_I: valid = b[19:0] >= `FPM_RATED_I_MIN && b[19:0] <= `FPM_RATED_I_MAX;
      fpm_pkg::SCR_SHUNT: valid = b[11:0] >= `FPM_SHUNT_MIN && b[11:0] <= `FPM_SHUNT_MAX;
      fpm_pkg::SCR_DATE: valid = b[15:8] >= `FPM_MONTH_MIN && b[15:8] <= `FPM_MONTH_MAX
                                 && b[7:0] >= `FPM_DAY_MIN && b[7:0] <= `FPM_DAY_MAX;
      fpm_pkg::SCR_TIME: valid = b[23:16] <= `FPM_HOUR_MAX;
      default: valid = 1'b1;
    endcase
  endfunction

  function automatic fpm_pkg::fpm_screen_t first_menu(input logic ind);
    first_menu = ind ? fpm_pkg::SCR_RATED_I : fpm_pkg::SCR_RATED_V;
  endfunction

  function automatic fpm_pkg::fpm_screen_t nxt(input fpm_pkg::fpm_screen_t s, input logic ind, input logic hall);
    unique case (s)
      fpm_pkg::SCR_METER: nxt = fpm_pkg::SCR_METER;
      fpm_pkg::SCR_PASS_IN: nxt = first_menu(ind);
      fpm_pkg::SCR_RATED_I: nxt = hall ? fpm_pkg::SCR_I_RANGE : fpm_pkg::SCR_SHUNT;
      fpm_pkg::SCR_SHUNT: nxt = fpm_pkg::SCR_RATED_V;
      fpm_pkg::SCR_I_RANGE: nxt = fpm_pkg::SCR_RATED_V;
      fpm_pkg::SCR_RATED_V: nxt = fpm_pkg::SCR_V_RANGE;
      fpm_pkg::SCR_V_RANGE: nxt = fpm_pkg::SCR_E_CLR;
      fpm_pkg::SCR_E_CLR: nxt = fpm_pkg::SCR_AH_CLR;
      fpm_pkg::SCR_AH_CLR: nxt = fpm_pkg::SCR_CNT_CLR;
      fpm_pkg::SCR_CNT_CLR: nxt = fpm_pkg::SCR_LAMP;
      fpm_pkg::SCR_LAMP: nxt = fpm_pkg::SCR_DATE;
      fpm_pkg::SCR_DATE: nxt = fpm_pkg::SCR_TIME;
      fpm_pkg::SCR_TIME: nxt = fpm_pkg::SCR_PASS_SET;
      fpm_pkg::SCR_PASS_SET: nxt = first_menu(ind);
      default: nxt = fpm_pkg::SCR_METER;
    endcase
  endfunction

  // ==================================================
  // Next state
  always_comb begin
    logic [3:0] dig;
    logic [3:0] dmax;
    dig = st_q.ebuf[st_q.cursor*4 +: 4];
    dmax = dig_max(st_q.screen, st_q.cursor);
    st_d = st_q;
    st_d.pulse = '0;
    st_d.inc_prev = inc_s;
    st_d.adv_prev = adv_s;
    if (inc_s && adv_s) begin
      st_d.combo_seen = 1'b1;
    end else if (!inc_s && !adv_s) begin
      st_d.combo_seen = 1'b0;
    end
    if (ev_combo) begin
      st_d.edit = 1'b0;
      st_d.clr_cnt = 2'h0;
      if (st_q.screen == fpm_pkg::SCR_METER) begin
        st_d.screen = fpm_pkg::SCR_PASS_IN;
        st_d.set_icon = 1'b1;
        st_d.entry = 16'h0000;
      end else begin
        st_d.screen = fpm_pkg::SCR_METER;
        st_d.set_icon = 1'b0;
      end
    end else if (ev_inc && st_q.screen != fpm_pkg::SCR_METER) begin
      if (st_q.edit) begin
        st_d.ebuf[st_q.cursor*4 +: 4] = (dig >= dmax) ? 4'h0 : dig + 4'h1;
      end else begin
        case (st_q.screen)
          fpm_pkg::SCR_I_RANGE: st_d.sel = !st_q.sel;
          fpm_pkg::SCR_V_RANGE: st_d.sel = !st_q.sel;
          fpm_pkg::SCR_E_CLR,
          fpm_pkg::SCR_AH_CLR,
          fpm_pkg::SCR_CNT_CLR: st_d.clr_cnt = (st_q.clr_cnt == `FPM_CLR_YES) ? 2'h0 : st_q.clr_cnt + 2'h1;
          fpm_pkg::SCR_LAMP: st_d.lamp_sel = (st_q.lamp_sel >= `FPM_LAMP_MAX) ? `FPM_LAMP_MIN
                                             : st_q.lamp_sel + 3'h1;
          default: begin
            st_d.edit = 1'b1;
            st_d.cursor = ndig(st_q.screen) - 3'h1;
            st_d.ebuf = load(st_q, st_q.screen);
          end
        endcase
      end
    end else if (ev_adv && st_q.screen != fpm_pkg::SCR_METER) begin
      if (st_q.edit) begin
        if (st_q.cursor != 3'h0) begin
          st_d.cursor = st_q.cursor - 3'h1;
        end else begin
          st_d.edit = 1'b0;
          if (valid(st_q.screen, st_q.ebuf)) begin
            case (st_q.screen)
              fpm_pkg::SCR_PASS_IN: st_d.entry = st_q.ebuf[15:0];
              fpm_pkg::SCR_RATED_I: st_d.cfg.rated_i = st_q.ebuf[19:0];
              fpm_pkg::SCR_SHUNT: st_d.cfg.shunt_mv = st_q.ebuf[11:0];
              fpm_pkg::SCR_RATED_V: st_d.cfg.rated_v = st_q.ebuf[15:0];
              fpm_pkg::SCR_DATE: begin
                st_d.cfg.date = st_q.ebuf;
                st_d.pulse.date_load = 1'b1;
              end
              fpm_pkg::SCR_TIME: begin
                st_d.cfg.time_of_day = st_q.ebuf;
                st_d.pulse.time_load = 1'b1;
              end
              fpm_pkg::SCR_PASS_SET: st_d.cfg.pass = st_q.ebuf[15:0];
              default: st_d.cfg = st_q.cfg;
            endcase
          end
          if (st_q.screen == fpm_pkg::SCR_SHUNT) begin
            st_d.screen = nxt(st_q.screen, ind_s, hall_s);
          end
        end
      end else begin
        case (st_q.screen)
          fpm_pkg::SCR_I_RANGE: st_d.cfg.i_range = st_q.sel;
          fpm_pkg::SCR_V_RANGE: st_d.cfg.v_range = st_q.sel;
          fpm_pkg::SCR_E_CLR: st_d.pulse.energy_clr = st_q.clr_cnt == `FPM_CLR_YES;
          fpm_pkg::SCR_AH_CLR: st_d.pulse.charge_clr = st_q.clr_cnt == `FPM_CLR_YES;
          fpm_pkg::SCR_CNT_CLR: st_d.pulse.count_clr = st_q.clr_cnt == `FPM_CLR_YES;
          fpm_pkg::SCR_LAMP: st_d.cfg.lamp = st_q.lamp_sel;
          default: st_d.cfg = st_q.cfg;
        endcase
        if (st_q.screen == fpm_pkg::SCR_PASS_IN && st_q.entry != st_q.cfg.pass) begin
          st_d.screen = fpm_pkg::SCR_METER;
          st_d.set_icon = 1'b0;
          st_d.pulse.pass_fail = 1'b1;
        end else begin
          st_d.screen = nxt(st_q.screen, ind_s, hall_s);
        end
      end
      st_d.clr_cnt = 2'h0;
      st_d.lamp_sel = st_d.cfg.lamp;
      st_d.sel = (st_d.screen == fpm_pkg::SCR_V_RANGE) ? st_d.cfg.v_range : st_d.cfg.i_range;
    end
  end

  // ==================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.screen <= fpm_pkg::SCR_METER;
      st_q.lamp_sel <= `FPM_RST_LAMP;
      st_q.cfg.rated_i <= `FPM_RST_RATED_I;
      st_q.cfg.shunt_mv <= `FPM_RST_SHUNT_MV;
      st_q.cfg.rated_v <= `FPM_RST_RATED_V;
      st_q.cfg.lamp <= `FPM_RST_LAMP;
      st_q.cfg.date <= `FPM_RST_DATE;
      st_q.cfg.time_of_day <= `FPM_RST_TIME;
      st_q.cfg.pass <= `FPM_RST_PASS;
    end else begin
      st_q <= st_d;
    end
  end

  // ==================================================
  // Outputs
  assign screen = st_q.screen;
  assign set_icon = st_q.set_icon;
  assign edit_active = st_q.edit;
  assign cursor = st_q.cursor;
  assign edit_digits = st_q.ebuf;
  assign clear_count = st_q.clr_cnt;
  assign lamp_sel = st_q.lamp_sel;
  assign range_sel = st_q.sel;
  assign cfg = st_q.cfg;
  assign pulse = st_q.pulse;

  // ==================================================
  // Checks
  logic [3:0] cur_dig;
  logic [3:0] cur_max;
  assign cur_dig = st_q.ebuf[st_q.cursor*4 +: 4];
  assign cur_max = dig_max(st_q.screen, st_q.cursor);

  AST_ENTER_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ev_combo && st_q.screen == fpm_pkg::SCR_METER |=> st_q.screen == fpm_pkg::SCR_PASS_IN && st_q.set_icon)
    else $error("chord in metering did not open the passcode screen");

  AST_LEAVE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ev_combo && st_q.screen != fpm_pkg::SCR_METER |=> st_q.screen == fpm_pkg::SCR_METER && !st_q.set_icon)
    else $error("chord in setting mode did not return to metering");

  AST_DIGIT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    ev_inc && st_q.edit && st_q.screen != fpm_pkg::SCR_METER
    |=> cur_dig == (($past(cur_dig) >= $past(cur_max)) ? 4'h0 : $past(cur_dig) + 4'h1))
    else $error("flashing digit did not step or wrap");

  AST_CURSOR_MOVE: assert property (@(posedge clk) disable iff (!rst_n)
    ev_adv && st_q.edit && st_q.cursor != 3'h0 |=> st_q.edit && st_q.cursor == $past(st_q.cursor) - 3'h1)
    else $error("cursor did not move to the next digit");

  AST_LAST_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
    ev_adv && st_q.edit && st_q.cursor == 3'h0 && st_q.screen != fpm_pkg::SCR_METER |=> !st_q.edit)
    else $error("commit on last digit left the cursor flashing");

  AST_PASS_ADMIT: assert property (@(posedge clk) disable iff (!rst_n)
    ev_adv && !st_q.edit && st_q.screen == fpm_pkg::SCR_PASS_IN && st_q.entry == st_q.cfg.pass
    |=> st_q.screen == first_menu($past(ind_s)))
    else $error("matching passcode did not admit to the menu");

  AST_ENERGY_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    ev_adv && !st_q.edit && st_q.screen == fpm_pkg::SCR_E_CLR |=> st_q.pulse.energy_clr == $past(st_q.clr_cnt == 2'h2)
    ##1 !st_q.pulse.energy_clr)
    else $error("energy clear pulse wrong");

  AST_LAMP_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.cfg.lamp >= 3'h1 && st_q.cfg.lamp <= 3'h5 && st_q.lamp_sel >= 3'h1 && st_q.lamp_sel <= 3'h5)
    else $error("backlight level out of range");

  AST_DATE_TIME: assert property (@(posedge clk) disable iff (!rst_n)
    ev_adv && !st_q.edit && st_q.screen == fpm_pkg::SCR_DATE |=> st_q.screen == fpm_pkg::SCR_TIME)
    else $error("advance after date did not reach time screen");

  AST_HOURS_24: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.cfg.time_of_day[23:16] <= 8'h23)
    else $error("stored hours exceed 23");

  COV_ENTER: cover property (@(posedge clk) disable iff (!rst_n)
    ev_combo && st_q.screen == fpm_pkg::SCR_METER);
  COV_ADMIT: cover property (@(posedge clk) disable iff (!rst_n)
    st_q.screen == fpm_pkg::SCR_PASS_IN ##1 st_q.screen == fpm_pkg::SCR_RATED_I);
  COV_CLEAR: cover property (@(posedge clk) disable iff (!rst_n) st_q.pulse.energy_clr);
  COV_WRAP: cover property (@(posedge clk) disable iff (!rst_n) ev_inc && st_q.edit && cur_dig == cur_max);

endmodule

// File: fpm_operator.sv
`timescale 1ns/1ns
// ==================================================
// Operator at the two front-panel keys
module fpm_operator (
  // Clock
  input wire logic clk,
  // Key pins, high while pressed
  output logic inc_key,
  output logic adv_key
);
  int hold = 3;

  initial begin
    inc_key = 1'b0;
    adv_key = 1'b0;
  end

  // ==================================================
  // Press kind 0 increment, 1 advance, 2 both; n presses with release gaps
  task automatic press(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #10;
      inc_key = (k != 1);
      adv_key = (k != 0);
      repeat (hold) @(posedge clk);
      #10;
      inc_key = 1'b0;
      adv_key = 1'b0;
      repeat (6) @(posedge clk);
      #10;
    end
  endtask
endmodule

// File: front_panel_setup_menu_tb_top.sv
`timescale 1ns/1ns
module front_panel_setup_menu_tb_top;
  localparam int INC = 0;
  localparam int ADV = 1;
  localparam int BOTH = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic indirect_current = 1'b1;
  logic hall_current = 1'b1;
  logic inc_key;
  logic adv_key;
  fpm_pkg::fpm_screen_t screen;
  logic set_icon;
  logic edit_active;
  logic range_sel;
  logic [2:0] cursor;
  logic [2:0] lamp_sel;
  logic [23:0] edit_digits;
  logic [1:0] clear_count;
  fpm_pkg::fpm_cfg_t cfg;
  fpm_pkg::fpm_pulse_t pulse;
  fpm_pkg::fpm_screen_t clr_scr = fpm_pkg::SCR_METER;
  int mismatches = 0;
  int comparisons = 0;
  int pc [6] = '{default: 0};

  always #50 clk = ~clk;

  fpm_menu u_fpm_menu (.clk(clk), .rst_n(rst_n), .inc_key(inc_key), .adv_key(adv_key),
    .indirect_current(indirect_current), .hall_current(hall_current), .screen(screen),
    .set_icon(set_icon), .edit_active(edit_active), .cursor(cursor), .edit_digits(edit_digits),
    .clear_count(clear_count), .lamp_sel(lamp_sel), .range_sel(range_sel), .cfg(cfg), .pulse(pulse));

  fpm_operator u_fpm_operator (.clk(clk), .inc_key(inc_key), .adv_key(adv_key));

  // ==================================================
  // Pulse counters, index 5 energy down to 0 time load
  always @(negedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (rst_n === 1'b1 && pulse[i] === 1'b1) begin
        pc[i]++;
      end
    end
    if (pulse.energy_clr === 1'b1) begin
      clr_scr = screen;
    end
  end

  // ==================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic p(input int k, input int n);
    u_fpm_operator.press(k, n);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // ==================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge clk);
    #10;
    rst_n = 1'b1;
    chk(32'(screen), 32'(fpm_pkg::SCR_METER));
    chk(32'(cfg.pass), 32'h0);
    chk(32'(cfg.lamp), 32'h5);
    chk(32'(cfg.shunt_mv), 32'h100);
    chk(32'(cfg.rated_i), 32'h20);
    chk(32'({cfg.i_range, cfg.v_range}), 32'h0);
    p(INC, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_METER));
    p(BOTH, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_PASS_IN));
    chk(32'(set_icon), 32'h1);
    p(INC, 1);
    chk(32'(edit_active), 32'h1);
    chk(32'(cursor), 32'h3);
    p(INC, 1);
    chk(32'(edit_digits), 32'h1000);
    p(ADV, 1);
    chk(32'(cursor), 32'h2);
    p(ADV, 2);
    chk(32'(cursor), 32'h0);
    p(ADV, 1);
    chk(32'(edit_active), 32'h0);
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_METER));
    chk(32'(pc[2]), 32'h1);
    u_fpm_operator.hold = 8;
    p(BOTH, 1);
    p(ADV, 1);
    u_fpm_operator.hold = 3;
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_I));
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_I_RANGE));
    chk(32'(range_sel), 32'h0);
    p(INC, 1);
    chk(32'(range_sel), 32'h1);
    p(ADV, 1);
    chk(32'(cfg.i_range), 32'h1);
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_V));
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_V_RANGE));
    p(INC, 1);
    chk(32'(range_sel), 32'h1);
    p(INC, 1);
    chk(32'(range_sel), 32'h0);
    p(ADV, 1);
    chk(32'(cfg.v_range), 32'h0);
    for (int i = 0; i < 3; i++) begin
      chk(32'(clear_count), 32'h0);
      p(INC, (i == 1) ? 3 : 2);
      chk(32'(clear_count), (i == 1) ? 32'h0 : 32'h2);
      p(ADV, 1);
    end
    chk(32'(pc[5]), 32'h1);
    chk(32'(clr_scr), 32'(fpm_pkg::SCR_AH_CLR));
    chk(32'(pc[4]), 32'h0);
    chk(32'(pc[3]), 32'h1);
    chk(32'(lamp_sel), 32'h5);
    p(INC, 1);
    chk(32'(lamp_sel), 32'h1);
    p(INC, 1);
    p(ADV, 1);
    chk(32'(cfg.lamp), 32'h2);
    chk(32'(screen), 32'(fpm_pkg::SCR_DATE));
    p(INC, 1);
    p(ADV, 6);
    chk(32'(pc[1]), 32'h1);
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_TIME));
    p(INC, 1);
    chk(32'(cursor), 32'h5);
    p(INC, 3);
    chk(32'(edit_digits), 32'h0);
    p(INC, 1);
    p(ADV, 1);
    p(INC, 3);
    chk(32'(edit_digits), 32'h130000);
    p(ADV, 5);
    chk(32'(cfg.time_of_day), 32'h130000);
    chk(32'(pc[0]), 32'h1);
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_PASS_SET));
    p(INC, 2);
    p(ADV, 4);
    chk(32'(cfg.pass), 32'h1000);
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_I));
    p(INC, 1);
    chk(32'(cursor), 32'h4);
    p(INC, 5);
    chk(32'(edit_digits), 32'h50020);
    p(ADV, 5);
    chk(32'(edit_active), 32'h0);
    chk(32'(cfg.rated_i), 32'h20);
    p(INC, 2);
    p(ADV, 5);
    chk(32'(cfg.rated_i), 32'h10020);
    p(BOTH, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_METER));
    chk(32'(set_icon), 32'h0);
    hall_current = 1'b0;
    p(BOTH, 1);
    p(INC, 2);
    p(ADV, 5);
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_I));
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_SHUNT));
    p(INC, 1);
    chk(32'(edit_digits), 32'h100);
    p(INC, 1);
    chk(32'(edit_digits), 32'h0);
    p(ADV, 1);
    p(INC, 5);
    p(ADV, 2);
    chk(32'(cfg.shunt_mv), 32'h50);
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_V));
    p(BOTH, 1);
    indirect_current = 1'b0;
    p(BOTH, 1);
    p(INC, 2);
    p(ADV, 5);
    chk(32'(screen), 32'(fpm_pkg::SCR_RATED_V));
    p(ADV, 1);
    chk(32'(screen), 32'(fpm_pkg::SCR_V_RANGE));
    chk(32'(range_sel), 32'h0);
    p(INC, 1);
    chk(32'(range_sel), 32'h1);
    p(ADV, 1);
    chk(32'(cfg.v_range), 32'h1);
    chk(32'(screen), 32'(fpm_pkg::SCR_E_CLR));
    p(ADV, 1);
    chk(32'(pc[5]), 32'h1);
    chk(32'(screen), 32'(fpm_pkg::SCR_AH_CLR));
    p(INC, 2);
    chk(32'(clear_count), 32'h2);
    p(ADV, 1);
    chk(32'(pc[4]), 32'h1);
    results();
  end
endmodule
